// ==== pkg/sensor_irq_map.vh ====
// register offsets, field positions, reset values and timing constants
`ifndef SENSOR_IRQ_MAP_VH
`define SENSOR_IRQ_MAP_VH
`define OFF_MAIN_IRQ_ENABLE 8'h10
`define OFF_RAW_READY_IRQ_ENABLE 8'h11
`define OFF_FIFO_OVERFLOW_IRQ_ENABLE 8'h12
`define OFF_FIFO_WATERMARK_IRQ_ENABLE 8'h13
`define OFF_PIN_CONFIG 8'h0f
`define OFF_TARGET4_CONTROL 8'h20
`define OFF_AUX_MASTER_EVENT_STATUS 8'h17
`define OFF_MAIN_IRQ_STATUS 8'h19
`define OFF_RAW_READY_IRQ_STATUS 8'h1a
`define OFF_FIFO_OVERFLOW_IRQ_STATUS 8'h1b
`define OFF_FIFO_WATERMARK_IRQ_STATUS 8'h1c
`define OFF_SYNC_DELAY_HIGH_BYTE 8'h28
`define OFF_SYNC_DELAY_LOW_BYTE 8'h29
`define REG_RESET 8'h00
`define BIT_AUX_MASTER_IRQ_EN 0
`define BIT_FRAME_SYNC_IRQ_MODE_EN 2
`define BIT_TARGET4_DONE_IRQ_EN 6
`define BIT_AUX_PASS 7
`define BIT_AUX_DONE 6
`define BIT_AUX_ARB 5
`define BIT_MAIN_WOM 3
`define BIT_MAIN_PLL 2
`define BIT_MAIN_MP 1
`define BIT_MAIN_AUX 0
`define FIFO_FIELD_W 5
`define PLL_LOCK_WAIT_US 4000
`define CLK_PERIOD_NS 10
`define DELAY_TICK_PS 964500
`endif

// ==== rtl/pulse_sync.v ====
// two-flop synchroniser with rising edge pulse
`timescale 1ns/1ps
module pulse_sync
(
  input wire clk_sys_in,
  input wire rst_in,
  input wire async_in,
  output wire level_out,
  output wire rise_out
);
  reg meta_q;
  reg sync_q;
  reg prev_q;
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign level_out = sync_q;
  assign rise_out = sync_q & ~prev_q;
endmodule

// ==== rtl/sensor_interrupt_status_enable.v ====
// interrupt enable/status registers, aux master status and sync delay over apb
`timescale 1ns/1ps
`include "sensor_irq_map.vh"
// Summary of operation
// - raw ready enable bit 0 routes raw data ready status to interrupt pin.
// - five overflow enables gate matching fifo overflow onto interrupt pin.
// - five watermark enables gate matching fifo watermark onto interrupt pin.
// - reading aux master status returns bits then clears all of them.
// - bit 7 shows frame-sync status; interrupts only with frame-sync mode enable.
// - bit 6 sets on target 4 done; interrupts with both enables set.
// - bit 5 sets on lost arbitration; interrupts with aux master enable.
// - bits 4..0 set on target 4..0 nack; interrupt with aux master enable.
// - main status bit 3 reads one after a wake-on-motion event.
// - main status bit 2 sets once pll enabled and 4 ms lock wait elapsed.
// - main status bit 1 sets on motion processor first interrupt.
// - main status bit 0 sets when aux master produced an interrupt.
// - extra status bit 0 sets when all raw sensor data updated.
// - overflow status bits 4:0 set on matching fifo overflow.
// - watermark status bits 4:0 set on matching fifo watermark.
// - status registers clear on read and reset to zero.
// - delay from frame-sync to next gyro rate event read as two bytes.
// - reading delay high byte freezes both delay bytes.
// - reading delay low byte releases the freeze.
// - delay is high*256+low counts of 97 clock cycles (0.97 us) each, the 0.9645 us tick rounded up.
// - three extra enable registers read-write, reset zero, reserved bits zero.
// - main enable bit 0 gates aux master events onto interrupt pin, except bit 7 frame-sync pass-through.
module sensor_interrupt_status_enable
#(
  parameter PLL_WAIT_CYCLES = `PLL_LOCK_WAIT_US * 1000 / `CLK_PERIOD_NS,
  parameter DELAY_TICK_CYCLES = (`DELAY_TICK_PS + `CLK_PERIOD_NS * 1000 - 1)
    / (`CLK_PERIOD_NS * 1000)
)
(
  input wire clk_sys_in,
  input wire rst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [31:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [3:0] pstrb_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  input wire raw_data_ready_in,
  input wire [4:0] fifo_overflow_in,
  input wire [4:0] fifo_watermark_in,
  input wire motion_wake_in,
  input wire pll_enabled_in,
  input wire motion_processor_irq1_in,
  input wire aux_target4_done_in,
  input wire aux_arbitration_lost_in,
  input wire [4:0] aux_target_nack_in,
  input wire frame_sync_input_in,
  input wire output_data_rate_in,
  output reg irq_pin1_out
);
  localparam FW = `FIFO_FIELD_W;
  localparam [31:0] PLL_LIMIT = PLL_WAIT_CYCLES - 1;

  reg [7:0] main_enable_q;
  reg [7:0] pin_config_q;
  reg [7:0] target4_control_q;
  reg raw_enable_q;
  reg [FW-1:0] overflow_enable_q;
  reg [FW-1:0] watermark_enable_q;
  reg [7:0] aux_status_q;
  reg [3:0] main_status_q;
  reg raw_status_q;
  reg [FW-1:0] overflow_status_q;
  reg [FW-1:0] watermark_status_q;
  reg [31:0] pll_count_q;
  reg pll_ready_q;
  reg pll_ready_seen_q;
  reg mp_irq_prev_q;
  reg aux_irq_prev_q;
  reg [7:0] read_data_d;
  reg addr_ok_d;

  wire fs_level;
  wire fs_rise;
  wire [15:0] delay_value;

  // byte address is four times the printed register offset
  function is_reg;
    input [31:0] addr;
    input [7:0] off;
    begin
      is_reg = (addr == {22'h00_0000, off, 2'b00});
    end
  endfunction

  // whole apb access completes in the first access cycle
  wire setup = psel_in & ~penable_in;
  wire access = psel_in & penable_in;
  wire wr = access & pwrite_in & pstrb_in[0];
  wire rd = access & ~pwrite_in;
  wire rd_aux = rd & is_reg(paddr_in, `OFF_AUX_MASTER_EVENT_STATUS);
  wire rd_main = rd & is_reg(paddr_in, `OFF_MAIN_IRQ_STATUS);
  wire rd_raw = rd & is_reg(paddr_in, `OFF_RAW_READY_IRQ_STATUS);
  wire rd_ovf = rd & is_reg(paddr_in, `OFF_FIFO_OVERFLOW_IRQ_STATUS);
  wire rd_wm = rd & is_reg(paddr_in, `OFF_FIFO_WATERMARK_IRQ_STATUS);
  wire rd_dh = rd & is_reg(paddr_in, `OFF_SYNC_DELAY_HIGH_BYTE);
  wire rd_dl = rd & is_reg(paddr_in, `OFF_SYNC_DELAY_LOW_BYTE);
  // write strobes, one per writable register
  wire wr_main_en = wr & is_reg(paddr_in, `OFF_MAIN_IRQ_ENABLE);
  wire wr_pin_cfg = wr & is_reg(paddr_in, `OFF_PIN_CONFIG);
  wire wr_t4_ctl = wr & is_reg(paddr_in, `OFF_TARGET4_CONTROL);
  wire wr_raw_en = wr & is_reg(paddr_in, `OFF_RAW_READY_IRQ_ENABLE);
  wire wr_ovf_en = wr & is_reg(paddr_in, `OFF_FIFO_OVERFLOW_IRQ_ENABLE);
  wire wr_wm_en = wr & is_reg(paddr_in, `OFF_FIFO_WATERMARK_IRQ_ENABLE);

  // the frame-sync pin is asynchronous, so two flops come before any logic
  pulse_sync frame_sync_sync
  (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .async_in(frame_sync_input_in),
    .level_out(fs_level),
    .rise_out(fs_rise)
  );

  // high byte read freezes both bytes, low byte read releases them
  // release wins if both land together, so the pair never stays locked
  sync_delay_timer #(.TICK_CYCLES(DELAY_TICK_CYCLES)) delay_timer
  (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .frame_sync_event_in(fs_rise),
    .output_data_rate_event_in(output_data_rate_in),
    .freeze_in(rd_dh),
    .release_in(rd_dl),
    .delay_out(delay_value)
  );

  // enabled aux events feeding the aux master summary flag
  wire aux_irq_cause =
    (main_enable_q[`BIT_AUX_MASTER_IRQ_EN] & aux_status_q[`BIT_AUX_ARB]) |
    (main_enable_q[`BIT_AUX_MASTER_IRQ_EN] & (|aux_status_q[4:0])) |
    (main_enable_q[`BIT_AUX_MASTER_IRQ_EN] &
     target4_control_q[`BIT_TARGET4_DONE_IRQ_EN] & aux_status_q[`BIT_AUX_DONE]);
  wire pass_irq = pin_config_q[`BIT_FRAME_SYNC_IRQ_MODE_EN] & aux_status_q[`BIT_AUX_PASS];

  // raw event vectors, one bit per status position
  wire [7:0] aux_events = {fs_level,
    aux_target4_done_in,
    aux_arbitration_lost_in,
    aux_target_nack_in};
  // pass-through is edge tracked too, so a held pin sets main bit 0 once
  wire master_cause = aux_irq_cause | pass_irq;
  wire [3:0] main_events = {motion_wake_in,
    pll_ready_q & ~pll_ready_seen_q,
    motion_processor_irq1_in & ~mp_irq_prev_q,
    master_cause & ~aux_irq_prev_q};

  // pll ready after lock wait
  // the count restarts whenever the pll is switched off
  always @(posedge clk_sys_in)
  begin
    if (rst_in || !pll_enabled_in)
    begin
      pll_count_q <= 32'h0000_0000;
      pll_ready_q <= 1'b0;
    end
    else if (!pll_ready_q)
    begin
      if (pll_count_q == PLL_LIMIT)
        pll_ready_q <= 1'b1;
      else
        pll_count_q <= pll_count_q + 32'h0000_0001;
    end
  end

  // edge trackers for the level-style event sources
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      pll_ready_seen_q <= 1'b0;
      mp_irq_prev_q <= 1'b0;
      aux_irq_prev_q <= 1'b0;
    end
    else
    begin
      pll_ready_seen_q <= pll_ready_q;
      mp_irq_prev_q <= motion_processor_irq1_in;
      aux_irq_prev_q <= master_cause;
    end
  end

  // status flags: a set in the same cycle as a clearing read wins,
  // but an event set at the setup edge is cleared one edge later without being read
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
      aux_status_q <= `REG_RESET;
    else
      aux_status_q <= (rd_aux ? `REG_RESET : aux_status_q) | aux_events;
  end

  // bit 3 follows every high wake cycle, bits 2..0 latch edges
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
      main_status_q <= 4'h0;
    else
      main_status_q <= (rd_main ? 4'h0 : main_status_q) | main_events;
  end

  // extra status flags follow the same set-wins rule
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
      raw_status_q <= 1'b0;
    else
      raw_status_q <= (raw_status_q & ~rd_raw) | raw_data_ready_in;
  end

  always @(posedge clk_sys_in)
  begin
    if (rst_in)
      overflow_status_q <= {FW{1'b0}};
    else
      overflow_status_q <= (rd_ovf ? {FW{1'b0}} : overflow_status_q) | fifo_overflow_in;
  end

  always @(posedge clk_sys_in)
  begin
    if (rst_in)
      watermark_status_q <= {FW{1'b0}};
    else
      watermark_status_q <= (rd_wm ? {FW{1'b0}} : watermark_status_q) | fifo_watermark_in;
  end

  // neighbouring config bits that gate the aux and pass-through causes
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      main_enable_q <= `REG_RESET;
      pin_config_q <= `REG_RESET;
      target4_control_q <= `REG_RESET;
    end
    else
    begin
      if (wr_main_en)
        main_enable_q <= pwdata_in[7:0];
      if (wr_pin_cfg)
        pin_config_q <= pwdata_in[7:0];
      if (wr_t4_ctl)
        target4_control_q <= pwdata_in[7:0];
    end
  end

  // extra enables: reserved upper bits are not stored and read as zero
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      raw_enable_q <= 1'b0;
      overflow_enable_q <= {FW{1'b0}};
      watermark_enable_q <= {FW{1'b0}};
    end
    else
    begin
      if (wr_raw_en)
        raw_enable_q <= pwdata_in[0];
      if (wr_ovf_en)
        overflow_enable_q <= pwdata_in[FW-1:0];
      if (wr_wm_en)
        watermark_enable_q <= pwdata_in[FW-1:0];
    end
  end

  // read mux
  always @*
  begin
    read_data_d = 8'h00;
    addr_ok_d = 1'b1;
    case (paddr_in[9:2])
      `OFF_MAIN_IRQ_ENABLE: read_data_d = main_enable_q;
      `OFF_PIN_CONFIG: read_data_d = pin_config_q;
      `OFF_TARGET4_CONTROL: read_data_d = target4_control_q;
      `OFF_RAW_READY_IRQ_ENABLE: read_data_d = {7'h00, raw_enable_q};
      `OFF_FIFO_OVERFLOW_IRQ_ENABLE: read_data_d = {3'h0, overflow_enable_q};
      `OFF_FIFO_WATERMARK_IRQ_ENABLE: read_data_d = {3'h0, watermark_enable_q};
      `OFF_AUX_MASTER_EVENT_STATUS: read_data_d = aux_status_q;
      `OFF_MAIN_IRQ_STATUS: read_data_d = {4'h0, main_status_q};
      `OFF_RAW_READY_IRQ_STATUS: read_data_d = {7'h00, raw_status_q};
      `OFF_FIFO_OVERFLOW_IRQ_STATUS: read_data_d = {3'h0, overflow_status_q};
      `OFF_FIFO_WATERMARK_IRQ_STATUS: read_data_d = {3'h0, watermark_status_q};
      `OFF_SYNC_DELAY_HIGH_BYTE: read_data_d = delay_value[15:8];
      `OFF_SYNC_DELAY_LOW_BYTE: read_data_d = delay_value[7:0];
      default: addr_ok_d = 1'b0;
    endcase
    if (paddr_in[31:10] != 22'h00_0000 || paddr_in[1:0] != 2'b00)
      addr_ok_d = 1'b0;
  end

  // registered answer: pready stands in the first access cycle, no wait state
  // read data is captured at the setup edge so it stands beside pready
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out <= setup;
      pslverr_out <= setup & ~addr_ok_d;
      if (setup)
        prdata_out <= pwrite_in ? 32'h0000_0000 : {24'h00_0000, read_data_d};
    end
  end

  // per-fifo gating, one slice per fifo
  wire [FW-1:0] fifo_hit;
  genvar gi;
  generate
    for (gi = 0; gi < FW; gi = gi + 1)
    begin : g_fifo_hit
      assign fifo_hit[gi] = (overflow_enable_q[gi] & overflow_status_q[gi]) |
        (watermark_enable_q[gi] & watermark_status_q[gi]);
    end
  endgenerate

  wire raw_hit = raw_enable_q & raw_status_q;
  // each main status bit has its own enable at the same position
  wire main_hit =
    (main_enable_q[`BIT_AUX_MASTER_IRQ_EN] & main_status_q[`BIT_MAIN_AUX]) |
    (main_enable_q[`BIT_MAIN_MP] & main_status_q[`BIT_MAIN_MP]) |
    (main_enable_q[`BIT_MAIN_PLL] & main_status_q[`BIT_MAIN_PLL]) |
    (main_enable_q[`BIT_MAIN_WOM] & main_status_q[`BIT_MAIN_WOM]);

  // pin driven from a flop, one cycle behind the status
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
      irq_pin1_out <= 1'b0;
    else
      irq_pin1_out <= raw_hit | (|fifo_hit) | main_hit | pass_irq;
  end
endmodule

// ==== rtl/sync_delay_timer.v ====
// frame-sync to gyro output_data_rate delay counter with read freeze
`timescale 1ns/1ps
`include "sensor_irq_map.vh"
module sync_delay_timer
#(
  parameter TICK_CYCLES = 96
)
(
  input wire clk_sys_in,
  input wire rst_in,
  input wire frame_sync_event_in,
  input wire output_data_rate_event_in,
  input wire freeze_in,
  input wire release_in,
  output reg [15:0] delay_out
);
  reg running_q;
  reg frozen_q;
  reg [15:0] count_q;
  reg [15:0] tick_q;
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;
  wire tick_done = ({16'h0000, tick_q} == TICK_LAST);
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      running_q <= 1'b0;
      frozen_q <= 1'b0;
      count_q <= 16'h0000;
      tick_q <= 16'h0000;
      delay_out <= 16'h0000;
    end
    else
    begin
      // release wins so a freeze-then-release pair always ends unfrozen
      if (release_in)
        frozen_q <= 1'b0;
      else if (freeze_in)
        frozen_q <= 1'b1;
      if (frame_sync_event_in)
      begin
        running_q <= 1'b1;
        count_q <= 16'h0000;
        tick_q <= 16'h0000;
      end
      else if (running_q)
      begin
        if (output_data_rate_event_in)
        begin
          running_q <= 1'b0;
          if (!frozen_q)
            delay_out <= count_q;
        end
        tick_q <= tick_done ? 16'h0000 : tick_q + 16'h0001;
        if (tick_done && count_q != 16'hffff)
          count_q <= count_q + 16'h0001;
      end
    end
  end
endmodule

// ==== testbench/odr_source.sv ====
// gyro rate source answering each frame-sync rise after a set gap
`timescale 1ns/1ps
module odr_source
(
  input wire clk_sys_in,
  input wire frame_sync_in,
  input wire [7:0] gap_in,
  output logic odr_out
);
  logic fs_q = 1'b0;
  logic [7:0] cnt_q = 8'h00;
  initial odr_out = 1'b0;
  // zero count means idle, so only one rate event follows each frame-sync rise
  always @(posedge clk_sys_in)
  begin
    fs_q <= frame_sync_in;
    odr_out <= (cnt_q == 8'h01);
    if (frame_sync_in && !fs_q)
      cnt_q <= gap_in;
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
endmodule

// ==== testbench/sensor_irq_sva.sv ====
// port-level checks of the interrupt status and enable block
`timescale 1ns/1ps
module sensor_irq_sva
(
  input wire clk_sys_in,
  input wire rst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [31:0] paddr_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  input wire irq_pin1_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  wire rd_acc = pready_out && psel_in && !pwrite_in;
  a_answer_first_access: assert property (psel_in && !penable_in |=> pready_out && penable_in)
    else $error("no answer in first access cycle");
  a_ready_in_access: assert property (pready_out |-> psel_in && penable_in)
    else $error("pready outside access phase");
  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  a_err_unmapped: assert property (psel_in && !penable_in && paddr_in[31:8] != 24'h00_0000
    |=> pslverr_out && prdata_out == 32'h0000_0000) else $error("unmapped access not refused");
  a_aux_mapped: assert property (psel_in && !penable_in && paddr_in == 32'h0000_005c
    |=> !pslverr_out) else $error("aux status refused");
  a_main_reserved: assert property (rd_acc && paddr_in == 32'h0000_0064
    |-> prdata_out[31:4] == 28'h000_0000) else $error("main status reserved bits set");
  a_raw_reserved: assert property (rd_acc && paddr_in == 32'h0000_0068
    |-> prdata_out[31:1] == 31'h0000_0000) else $error("raw status reserved bits set");
  a_enable_reserved: assert property (rd_acc && paddr_in[31:3] == 29'h0000_0009
    |-> prdata_out[31:5] == 27'h000_0000) else $error("enable reserved bits set");
  a_irq_after_reset: assert property ($fell(rst_in) |-> !irq_pin1_out && !pready_out)
    else $error("outputs active after reset");
  c_unmapped: cover property (pslverr_out);
  c_irq: cover property ($rose(irq_pin1_out));
  c_delay_read: cover property (rd_acc && paddr_in == 32'h0000_00a0);
endmodule
bind sensor_interrupt_status_enable sensor_irq_sva u_sva
(
  .clk_sys_in(clk_sys_in),
  .rst_in(rst_in),
  .psel_in(psel_in),
  .penable_in(penable_in),
  .pwrite_in(pwrite_in),
  .paddr_in(paddr_in),
  .prdata_out(prdata_out),
  .pready_out(pready_out),
  .pslverr_out(pslverr_out),
  .irq_pin1_out(irq_pin1_out)
);

// ==== testbench/testbench.sv ====
// self-checking bench for the interrupt status and enable block
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, raw = 0, wake = 0, pll = 0, mp = 0;
  logic done4 = 0, arb = 0, fs = 0, odr, prdy, perr, irq, ev;
  logic [4:0] ov = 0, wm = 0, nack = 0;
  logic [7:0] gap = 8'h1e;
  logic [31:0] pa = 0, pw = 0, prd, v;
  logic [11:0] addrs[10] = '{12'h044, 12'h048, 12'h04c, 12'h05c, 12'h064,
    12'h068, 12'h06c, 12'h070, 12'h0a0, 12'h0a4};
  int error_cnt = 0, cmp_count = 0;
  sensor_interrupt_status_enable #(.PLL_WAIT_CYCLES(10), .DELAY_TICK_CYCLES(3)) u_dut (
    .clk_sys_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(pa), .pwdata_in(pw), .pstrb_in(4'hf), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(perr), .raw_data_ready_in(raw), .fifo_overflow_in(ov),
    .fifo_watermark_in(wm), .motion_wake_in(wake), .pll_enabled_in(pll),
    .motion_processor_irq1_in(mp), .aux_target4_done_in(done4),
    .aux_arbitration_lost_in(arb), .aux_target_nack_in(nack), .frame_sync_input_in(fs),
    .output_data_rate_in(odr), .irq_pin1_out(irq));
  odr_source u_odr (.clk_sys_in(clk), .frame_sync_in(fs), .gap_in(gap), .odr_out(odr));
  initial forever #5 clk = ~clk;
  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp, input string nm);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // request held until pready is sampled high, then released
  task xfer(input logic w, input [11:0] a, input [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    pa <= {20'h0_0000, a};
    pw <= d;
    @(posedge clk);
    pen <= 1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (prdy !== 1'b1 && n < 20);
    if (prdy !== 1'b1)
      error_cnt++;
    v = prd;
    ev = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task rd(input [11:0] a, input [31:0] e);
    xfer(0, a, 32'h0000_0000);
    chk(v, e, $sformatf("reg %h", a));
  endtask
  task wr(input [11:0] a, input [31:0] d);
    xfer(1, a, d);
  endtask
  task irqis(input logic e);
    chk({31'h0000_0000, irq}, {31'h0000_0000, e}, "irq_pin1");
  endtask
  initial
  begin
    #50000;
    error_cnt++;
    give_verdict;
  end
  initial
  begin
    tick(16);
    rst <= 0;
    foreach (addrs[i]) rd(addrs[i], 32'h0000_0000);
    rd(12'h300, 32'h0000_0000);
    chk({31'h0000_0000, ev}, 32'h0000_0001, "pslverr");
    wr(12'h044, 32'h0000_00ff);
    wr(12'h048, 32'h0000_00ff);
    wr(12'h04c, 32'h0000_00ff);
    rd(12'h044, 32'h0000_0001);
    rd(12'h048, 32'h0000_001f);
    rd(12'h04c, 32'h0000_001f);
    $display("test registers done");
    raw <= 1;
    tick(1);
    raw <= 0;
    tick(4);
    irqis(1);
    rd(12'h068, 32'h0000_0001);
    rd(12'h068, 32'h0000_0000);
    irqis(0);
    wr(12'h044, 32'h0000_0000);
    raw <= 1;
    tick(1);
    raw <= 0;
    tick(4);
    irqis(0);
    rd(12'h068, 32'h0000_0001);
    ov <= 5'h10;
    wm <= 5'h01;
    tick(1);
    ov <= 5'h00;
    wm <= 5'h00;
    tick(4);
    irqis(1);
    rd(12'h06c, 32'h0000_0010);
    rd(12'h070, 32'h0000_0001);
    tick(2);
    irqis(0);
    wr(12'h048, 32'h0000_000f);
    ov <= 5'h10;
    tick(1);
    ov <= 5'h00;
    tick(4);
    irqis(0);
    rd(12'h06c, 32'h0000_0010);
    $display("test raw and fifo done");
    wr(12'h040, 32'h0000_0001);
    nack <= 5'h05;
    arb <= 1;
    tick(1);
    nack <= 5'h00;
    arb <= 0;
    tick(4);
    irqis(1);
    rd(12'h05c, 32'h0000_0025);
    rd(12'h05c, 32'h0000_0000);
    rd(12'h064, 32'h0000_0001);
    tick(2);
    irqis(0);
    done4 <= 1;
    tick(1);
    done4 <= 0;
    tick(4);
    irqis(0);
    rd(12'h05c, 32'h0000_0040);
    wr(12'h080, 32'h0000_0040);
    done4 <= 1;
    tick(1);
    done4 <= 0;
    tick(4);
    irqis(1);
    rd(12'h05c, 32'h0000_0040);
    rd(12'h064, 32'h0000_0001);
    $display("test aux done");
    wake <= 1;
    mp <= 1;
    pll <= 1;
    tick(1);
    wake <= 0;
    tick(20);
    irqis(0);
    rd(12'h064, 32'h0000_000e);
    $display("test main done");
    wr(12'h03c, 32'h0000_0004);
    fs <= 1;
    tick(60);
    irqis(1);
    rd(12'h05c, 32'h0000_0080);
    fs <= 0;
    tick(4);
    rd(12'h0a0, 32'h0000_0000);
    gap <= 8'h5a;
    fs <= 1;
    tick(120);
    fs <= 0;
    xfer(0, 12'h0a4, 32'h0000_0000);
    chk(v >= 8 && v <= 10, 1, "delay held");
    fs <= 1;
    tick(120);
    fs <= 0;
    rd(12'h0a0, 32'h0000_0000);
    xfer(0, 12'h0a4, 32'h0000_0000);
    chk(v >= 28 && v <= 30, 1, "delay new");
    $display("test delay done");
    give_verdict;
  end
endmodule
